/* hw/dlsa_regs.v */
// Purpose: system side control and status registers of the debug link access layer
// Assumes: one clock, synchronous active low reset, one cycle read/write strobes
// Notes: read data is registered, one cycle after the read strobe
//
// Functional notes
// R1: select field picks 16, 8, 4 MHz
// R2: select field resets to 4 MHz setting
// R3: debugger keeps 4 MHz unless brownout highest
// R4: writing done bit starts user row program
// R5: debugger writes done after data in RAM
// R6: done bit writable only with key decoded
// R7: clock request bit requests system clock always
// R8: clock request cleared when link disabled
// R9: clock request set on programming mode enable
// R10: reset active bit shows system reset
// R11: reading status clears reset active bit
// R12: sleep bit shows idle or deeper sleep
// R13: nvm ready bit shows programming may start
// R14: debugger resets system after nvm programming
// R15: user row ready bit shows programming may start
// R16: lock bit one when locked, reset one
// R17: crc field one-hot status encoding
// R18: reset signature asserts, zero releases system reset
// R19: link disable resets all configuration and keys
// R20: reserved bits read zero, writes ignored
`timescale 1ns/1ps
`include "dlsa_defines.vh"
module dlsa_regs #(
    parameter ADDR_W = 4
) (
    input wire clk,
    input wire rstn,
    input wire link_disable,
    input wire prog_mode_enable,
    input wire reg_wr,
    input wire reg_rd,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_ff,
    input wire user_row_key_ok,
    input wire sys_reset_in,
    input wire sys_sleep_in,
    input wire nvm_prog_ok_in,
    input wire user_row_prog_ok_in,
    input wire lock_in,
    input wire [2:0] crc_status_in,
    output reg [1:0] link_clock_divider_select_ff,
    output reg system_clock_request_ff,
    output reg user_row_program_done_ff,
    output reg system_reset_hold_ff,
    output wire system_reset_req
);

    reg [7:0] reset_request_field_ff;
    reg system_reset_active_ff;
    reg lock_ff;
    wire live_rstn;
    wire wr_sel;
    wire wr_ctrl;
    wire wr_req;
    wire rd_stat;
    reg [1:0] nxt_sel;
    reg [7:0] nxt_rdata;

    function hit;
        input [ADDR_W-1:0] a;
        input [3:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    assign live_rstn = rstn & ~link_disable; // R19
    assign wr_sel = reg_wr & hit(reg_addr, `DLSA_OFS_CLK_SEL);
    assign wr_ctrl = reg_wr & hit(reg_addr, `DLSA_OFS_SYS_CTRL);
    assign wr_req = reg_wr & hit(reg_addr, `DLSA_OFS_RESET_REQ);
    assign rd_stat = reg_rd & hit(reg_addr, `DLSA_OFS_SYS_STAT);
    assign system_reset_req = system_reset_hold_ff;

    always @* begin
        nxt_sel = link_clock_divider_select_ff;
        if (wr_sel && reg_wdata[1:0] != 2'h0) begin
            nxt_sel = reg_wdata[1:0]; // R1
        end
    end

    always @(posedge clk) begin
        if (!live_rstn) begin
            link_clock_divider_select_ff <= `DLSA_CLK_SEL_RST; // R2
        end else begin
            link_clock_divider_select_ff <= nxt_sel;
        end
    end

    always @(posedge clk) begin
        if (!live_rstn) begin
            system_clock_request_ff <= 1'b0; // R8
        end else if (prog_mode_enable) begin
            system_clock_request_ff <= 1'b1; // R9
        end else if (wr_ctrl) begin
            system_clock_request_ff <= reg_wdata[`DLSA_BIT_SYSTEM_CLOCK_REQUEST]; // R7
        end
    end

    always @(posedge clk) begin
        if (!live_rstn) begin
            user_row_program_done_ff <= 1'b0;
        end else if (wr_ctrl && user_row_key_ok) begin
            user_row_program_done_ff <= reg_wdata[`DLSA_BIT_UROW_DONE]; // R4 R6
        end
    end

    always @(posedge clk) begin
        if (!live_rstn) begin
            reset_request_field_ff <= `DLSA_RESET_REQUEST_FIELD_RUN;
            system_reset_hold_ff <= 1'b0;
        end else if (wr_req) begin
            reset_request_field_ff <= reg_wdata;
            if (reg_wdata == `DLSA_RESET_REQUEST_FIELD_RESET) begin
                system_reset_hold_ff <= 1'b1; // R18
            end else if (reg_wdata == `DLSA_RESET_REQUEST_FIELD_RUN) begin
                system_reset_hold_ff <= 1'b0; // R18
            end
        end
    end

    always @(posedge clk) begin
        if (!live_rstn) begin
            system_reset_active_ff <= 1'b0;
        end else if (sys_reset_in || system_reset_hold_ff) begin
            system_reset_active_ff <= 1'b1; // R10
        end else if (rd_stat) begin
            system_reset_active_ff <= 1'b0; // R11
        end
    end

    always @(posedge clk) begin
        if (!live_rstn) begin
            lock_ff <= 1'b1; // R16
        end else begin
            lock_ff <= lock_in; // R16
        end
    end

    always @* begin
        nxt_rdata = 8'h00; // R20
        if (hit(reg_addr, `DLSA_OFS_RESET_REQ)) begin
            nxt_rdata = reset_request_field_ff;
        end else if (hit(reg_addr, `DLSA_OFS_CLK_SEL)) begin
            nxt_rdata[1:0] = link_clock_divider_select_ff;
        end else if (hit(reg_addr, `DLSA_OFS_SYS_CTRL)) begin
            nxt_rdata[`DLSA_BIT_SYSTEM_CLOCK_REQUEST] = system_clock_request_ff;
            nxt_rdata[`DLSA_BIT_UROW_DONE] = user_row_program_done_ff;
        end else if (hit(reg_addr, `DLSA_OFS_SYS_STAT)) begin
            nxt_rdata[`DLSA_BIT_RST_ACT] = system_reset_active_ff | system_reset_hold_ff; // R10
            nxt_rdata[`DLSA_BIT_SLEEP] = sys_sleep_in; // R12
            nxt_rdata[`DLSA_BIT_NVM_RDY] = nvm_prog_ok_in; // R13
            nxt_rdata[`DLSA_BIT_UROW_RDY] = user_row_prog_ok_in; // R15
            nxt_rdata[`DLSA_BIT_LOCK] = lock_ff; // R16
        end else if (hit(reg_addr, `DLSA_OFS_CRC_STAT)) begin
            case (crc_status_in)
                `DLSA_CRC_BUSY, `DLSA_CRC_OK, `DLSA_CRC_FAIL: begin
                    nxt_rdata[2:0] = crc_status_in; // R17
                end
                default: begin
                    nxt_rdata[2:0] = `DLSA_CRC_OFF;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (!live_rstn) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

endmodule

/* hw/dlsa_defines.vh */
// Purpose: constants for the access side system registers
// Assumes: byte wide register port, offsets as printed
// Notes: included by dlsa_regs.v
`ifndef DLSA_DEFINES_VH
`define DLSA_DEFINES_VH
`define DLSA_OFS_RESET_REQ 4'h8
`define DLSA_OFS_CLK_SEL 4'h9
`define DLSA_OFS_SYS_CTRL 4'ha
`define DLSA_OFS_SYS_STAT 4'hb
`define DLSA_OFS_CRC_STAT 4'hc
`define DLSA_CLK_SEL_RST 2'h3
`define DLSA_CLK_SEL_16M 2'h1
`define DLSA_CLK_SEL_8M 2'h2
`define DLSA_CLK_SEL_4M 2'h3
`define DLSA_BIT_SYSTEM_CLOCK_REQUEST 0
`define DLSA_BIT_UROW_DONE 1
`define DLSA_BIT_LOCK 0
`define DLSA_BIT_UROW_RDY 2
`define DLSA_BIT_NVM_RDY 3
`define DLSA_BIT_SLEEP 4
`define DLSA_BIT_RST_ACT 5
`define DLSA_RESET_REQUEST_FIELD_RESET 8'h59
`define DLSA_RESET_REQUEST_FIELD_RUN 8'h00
`define DLSA_CRC_OFF 3'h0
`define DLSA_CRC_BUSY 3'h1
`define DLSA_CRC_OK 3'h2
`define DLSA_CRC_FAIL 3'h4
`endif

/* sim/dlsa_dbg_model.sv */
// Purpose: debugger side of the register port
// Assumes: moves 1ns after the edge
// Notes: idle address and data lines show inverted values, strobes idle low
`timescale 1ns/1ps
module dlsa_dbg_model (
    input wire clk,
    input wire [7:0] reg_rdata_ff,
    output reg reg_wr = 1'h0,
    output reg reg_rd = 1'h0,
    output reg [3:0] reg_addr = 4'h0,
    output reg [7:0] reg_wdata = 8'h0
);
    task xfer(input wr, input [3:0] a, input [7:0] d, output [7:0] q);
        @(posedge clk) #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
        @(posedge clk) #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
        q = reg_rdata_ff;
    endtask
endmodule

/* sim/dlsa_regs_sva.sv */
// Purpose: port checks
// Assumes: link_disable resets
// Notes: bound below
`timescale 1ns/1ps
module dlsa_regs_sva (
    input wire clk, rstn, link_disable, prog_mode_enable, reg_wr, reg_rd, user_row_key_ok,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata, reg_rdata_ff,
    input wire [1:0] link_clock_divider_select_ff,
    input wire system_clock_request_ff, user_row_program_done_ff, system_reset_hold_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn || link_disable);
    wire [7:0] d = reg_wdata, q = reg_rdata_ff;
    wire [1:0] sel = link_clock_divider_select_ff;
    wire pm = prog_mode_enable, key = user_row_key_ok, req = system_clock_request_ff;
    wire done = user_row_program_done_ff, hold = system_reset_hold_ff;
    wire w8 = reg_wr && reg_addr == 4'h8, w9 = reg_wr && reg_addr == 4'h9;
    wire wa = reg_wr && reg_addr == 4'ha, rb = reg_rd && reg_addr == 4'hb;
    a_sel_wr: assert property (w9 && |d[1:0] |=> sel == $past(d[1:0])) else $error("sel");
    a_prog_req: assert property (pm |=> req) else $error("prog");
    a_req_wr: assert property (wa && !pm |=> req == $past(d[0])) else $error("req");
    a_done_key: assert property (wa && key |=> done == $past(d[1])) else $error("key");
    a_done_lock: assert property (wa && !key |=> $stable(done)) else $error("done");
    a_rst_sig: assert property (w8 && d == 8'h59 |=> hold) else $error("hold");
    a_rst_rd: assert property (rb && hold |=> q[5]) else $error("rst");
    a_resv_rd: assert property (rb |=> q[7:6] == 2'h0 && !q[1]) else $error("resv");
    c_sel: cover property (w9);
    c_key: cover property (wa && key);
    c_hold: cover property (rb && hold);
endmodule
bind dlsa_regs dlsa_regs_sva dlsa_regs_sva_inst (.*);

/* sim/dlsa_regs_tb_top.sv */
// Purpose: register tests
// Assumes: inputs move 1ns after the edge
// Notes: accesses go through the model
`timescale 1ns/1ps
module dlsa_regs_tb_top;
    reg clk = 1'h0, rstn = 1'h0, link_disable = 1'h0, prog_mode_enable = 1'h0, lock_in = 1'h1;
    reg user_row_key_ok = 1'h0, sys_reset_in = 1'h0, sys_sleep_in = 1'h0, nvm_prog_ok_in = 1'h0;
    reg user_row_prog_ok_in = 1'h0;
    reg [2:0] crc_status_in = 3'h0;
    wire reg_wr, reg_rd, system_clock_request_ff, user_row_program_done_ff;
    wire system_reset_hold_ff, system_reset_req;
    wire [1:0] link_clock_divider_select_ff;
    wire [3:0] reg_addr;
    wire [7:0] reg_wdata, reg_rdata_ff;
    reg [7:0] v, i;
    integer err_total = 0, n_checks = 0;
    dlsa_regs dlsa_regs_inst (.*);
    dlsa_dbg_model dlsa_dbg_model_inst (.*);
    initial forever #5 clk = ~clk;
    task chk(input [7:0] s, e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("Error %0t %h %h", $time, s, e);
        end
    endtask
    task w(input [3:0] a, input [7:0] d);
        dlsa_dbg_model_inst.xfer(1'h1, a, d, v);
    endtask
    task r(input [3:0] a, input [7:0] e);
        dlsa_dbg_model_inst.xfer(1'h0, a, 8'h0, v);
        chk(v, e);
    endtask
    task final_report;
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1 rstn = 1'h1;
        r(4'h9, 8'h03);
        r(4'hb, 8'h01);
        for (i = 8'h1; i < 8'h5; i++) begin
            w(4'h9, 8'hfc | i & 8'h3);
            r(4'h9, i[1:0] ? i & 8'h3 : 8'h3);
            chk({6'h0, link_clock_divider_select_ff}, i[1:0] ? i & 8'h3 : 8'h3);
        end
        w(4'ha, 8'hfb);
        r(4'ha, 8'h01);
        user_row_key_ok = 1'h1;
        w(4'ha, 8'h02);
        r(4'ha, 8'h02);
        {sys_reset_in, sys_sleep_in, nvm_prog_ok_in, user_row_prog_ok_in, lock_in} = 5'h1e;
        w(4'h8, 8'h59);
        chk({7'h0, system_reset_req}, 8'h01);
        sys_reset_in = 1'h0;
        r(4'hb, 8'h3c);
        w(4'h8, 8'h00);
        chk({7'h0, system_reset_req}, 8'h00);
        r(4'hb, 8'h3c);
        r(4'hb, 8'h1c);
        for (i = 8'h0; i < 8'h5; i++) begin
            crc_status_in = i[2:0];
            r(4'hc, i == 8'h3 ? 8'h0 : i);
        end
        r(4'hf, 8'h00);
        link_disable = 1'h1;
        @(posedge clk) #1;
        link_disable = 1'h0;
        r(4'ha, 8'h00);
        prog_mode_enable = 1'h1;
        r(4'ha, 8'h01);
        final_report;
    end
endmodule
